//--- core/lpdf_chan.sv
// one lane: receive glitch filter plus transmit stuck-low monitor
// assumes raw inputs already synchronised to i_clk
`timescale 1ns/1ps
`include "lpdf_regs.svh"
module lpdf_chan #(
  parameter int TMO_CYC = `LPDF_TX_TMO_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rx_raw,
  input wire lpdf_pkg::lpdf_cnt_t i_thr_rise,
  input wire lpdf_pkg::lpdf_cnt_t i_thr_fall,
  input wire logic i_txd,
  output logic o_rx_filt,
  output logic o_tx_en,
  output logic o_tmo_pulse
);
  localparam int TW = $clog2(TMO_CYC + 1);
  lpdf_pkg::lpdf_cnt_t flt_cnt_q;
  logic rx_q;
  logic [TW-1:0] tmo_cnt_q;
  lpdf_pkg::lpdf_mon_e mon_q;
  logic txd_prev_q;
  wire lpdf_pkg::lpdf_cnt_t thr_w;
  wire differ_w;
  wire flt_done_w;
  wire tx_rise_w;
  wire tmo_hit_w;
  // ****************************************
  // receive glitch filter
  // ****************************************
  // threshold depends on direction of the pending edge
  assign thr_w = rx_q ? i_thr_fall : i_thr_rise;
  assign differ_w = (i_rx_raw != rx_q);
  // zero threshold would never settle, so treat it as one cycle
  assign flt_done_w = differ_w && ((flt_cnt_q + 8'h01) >= thr_w);
  // count cycles of new level, reversal clears the count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flt_cnt_q <= 8'h00;
      rx_q <= 1'b1;
    end else if (!differ_w || flt_done_w) begin
      flt_cnt_q <= 8'h00;
      rx_q <= flt_done_w ? i_rx_raw : rx_q;
    end else begin
      flt_cnt_q <= flt_cnt_q + 8'h01;
    end
  end
  assign o_rx_filt = rx_q;
  // ****************************************
  // transmit timeout monitor
  // ****************************************
  assign tx_rise_w = i_txd && !txd_prev_q;
  assign tmo_hit_w = (mon_q == lpdf_pkg::LPDF_MON_RUN) && !i_txd &&
                     (tmo_cnt_q == TW'(TMO_CYC - 1));
  // driver stays off until txd rises again
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tmo_cnt_q <= '0;
      mon_q <= lpdf_pkg::LPDF_MON_RUN;
      txd_prev_q <= 1'b1;
    end else begin
      txd_prev_q <= i_txd;
      if (i_txd) begin
        tmo_cnt_q <= '0;
      end else if (mon_q == lpdf_pkg::LPDF_MON_RUN && !tmo_hit_w) begin
        tmo_cnt_q <= tmo_cnt_q + TW'(1);
      end
      if (tmo_hit_w) begin
        mon_q <= lpdf_pkg::LPDF_MON_OFF;
      end else if (tx_rise_w) begin
        mon_q <= lpdf_pkg::LPDF_MON_RUN;
      end
    end
  end
  assign o_tx_en = (mon_q == lpdf_pkg::LPDF_MON_RUN);
  assign o_tmo_pulse = tmo_hit_w;
endmodule : lpdf_chan

//--- core/lpdf_pkg.sv
// types shared by the lin front end design files
// assumes nothing beyond a systemverilog compiler
package lpdf_pkg;
  typedef logic [7:0] lpdf_cnt_t;
  typedef enum logic [0:0] {
    LPDF_MON_RUN = 1'b0,
    LPDF_MON_OFF = 1'b1
  } lpdf_mon_e;
endpackage : lpdf_pkg

//--- core/lpdf_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the front end design files
`ifndef LPDF_REGS_SVH
`define LPDF_REGS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LPDF_OFF_SLV_FILT 8'h00
`define LPDF_OFF_MST_FILT 8'h04
`define LPDF_OFF_CTRL 8'h08
`define LPDF_OFF_PINSEL 8'h0C
`define LPDF_OFF_STATUS 8'h10
`define LPDF_OFF_IRQ_EN 8'h14
`define LPDF_OFF_IRQ_CLR 8'h18
`define LPDF_OFF_LIVE 8'h1C
// ****************************************
// field positions
// ****************************************
`define LPDF_FILT_FALL_LSB 0
`define LPDF_FILT_RISE_LSB 8
`define LPDF_CTRL_SLV_SRC 0
`define LPDF_CTRL_SHORT_EN 1
`define LPDF_CTRL_SWITCH_EN 2
`define LPDF_CTRL_EXT_MODE 3
`define LPDF_PIN_SLV_34 0
`define LPDF_PIN_SLV_56 1
`define LPDF_PIN_MST_12 2
`define LPDF_ST_SLV_TMO 0
`define LPDF_ST_MST_TMO 1
`define LPDF_ST_PU_OFF 2
// ****************************************
// reset values and timing counts
// ****************************************
`define LPDF_THRES_RST 8'h30
`define LPDF_CTRL_RST 4'h0
`define LPDF_PIN_RST 3'h0
`define LPDF_TX_TMO_CYC 20000
`endif

//--- core/lpdf_top.sv
// lin phy digital front end: filters, tx monitors, routing, registers
// assumes all pin and phy inputs are asynchronous to I_MCLK
`timescale 1ns/1ps
`include "lpdf_regs.svh"
module lpdf_top #(
  parameter int TX_TMO_CYC = `LPDF_TX_TMO_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  input wire logic I_SLV_PHY_RX,
  input wire logic I_MST_PHY_RX,
  input wire logic I_SLV_CTRL_TX,
  input wire logic I_MST_CTRL_TX,
  input wire logic I_ALT_TX,
  input wire logic I_SLV_SHORT_GND,
  output logic O_SLV_CTRL_RX,
  output logic O_MST_CTRL_RX,
  output logic O_SLV_PHY_TX,
  output logic O_SLV_PHY_TX_EN,
  output logic O_MST_PHY_TX,
  output logic O_MST_PHY_TX_EN,
  output logic O_SLV_PULLUP_EN,
  input wire logic [6:1] I_GPIO,
  output logic [6:1] O_GPIO,
  output logic [6:1] O_GPIO_OE
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NS = 10;
  logic [NS-1:0] sy1_q;
  logic [NS-1:0] sy2_q;
  wire [NS-1:0] raw_w;
  assign raw_w = {I_GPIO, I_SLV_SHORT_GND, I_ALT_TX,
                  I_MST_PHY_RX, I_SLV_PHY_RX};
  // two flops, first one read only by the second
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sy1_q <= {NS{1'b1}};
      sy2_q <= {NS{1'b1}};
    end else begin
      sy1_q <= raw_w;
      sy2_q <= sy1_q;
    end
  end
  wire s_slv_rx = sy2_q[0];
  wire s_mst_rx = sy2_q[1];
  wire s_alt_tx = sy2_q[2];
  wire s_short = sy2_q[3];
  wire [6:1] s_gpio = sy2_q[NS-1:4];
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] slv_filt_q;
  logic [15:0] mst_filt_q;
  logic [3:0] ctrl_q;
  logic [2:0] pin_q;
  logic [2:0] stat_q;
  logic [2:0] irqen_q;
  logic [31:0] rdata_q;
  wire [2:0] ev_w;
  wire [2:0] clr_w;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit
  wire wr_sf = I_WR && hit(I_ADDR, `LPDF_OFF_SLV_FILT);
  wire wr_mf = I_WR && hit(I_ADDR, `LPDF_OFF_MST_FILT);
  wire wr_ct = I_WR && hit(I_ADDR, `LPDF_OFF_CTRL);
  wire wr_pn = I_WR && hit(I_ADDR, `LPDF_OFF_PINSEL);
  wire wr_ie = I_WR && hit(I_ADDR, `LPDF_OFF_IRQ_EN);
  wire wr_cl = I_WR && hit(I_ADDR, `LPDF_OFF_IRQ_CLR);
  assign clr_w = wr_cl ? I_WDATA[2:0] : 3'h0;
  // config writes; filter fields rise in high byte, fall in low
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      slv_filt_q <= {`LPDF_THRES_RST, `LPDF_THRES_RST};
      mst_filt_q <= {`LPDF_THRES_RST, `LPDF_THRES_RST};
      ctrl_q <= `LPDF_CTRL_RST;
      pin_q <= `LPDF_PIN_RST;
      irqen_q <= 3'h0;
    end else begin
      if (wr_sf) slv_filt_q <= I_WDATA[15:0];
      if (wr_mf) mst_filt_q <= I_WDATA[15:0];
      if (wr_ct) ctrl_q <= I_WDATA[3:0];
      if (wr_pn) pin_q <= I_WDATA[2:0];
      if (wr_ie) irqen_q <= I_WDATA[2:0];
    end
  end
  // sticky events, a new event beats a same-cycle clear
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~clr_w) | ev_w;
    end
  end
  assign O_IRQ = |(stat_q & irqen_q);
  // ****************************************
  // lanes
  // ****************************************
  wire ctrl_src = ctrl_q[`LPDF_CTRL_SLV_SRC];
  wire short_en = ctrl_q[`LPDF_CTRL_SHORT_EN];
  wire sw_en = ctrl_q[`LPDF_CTRL_SWITCH_EN];
  wire ext_en = ctrl_q[`LPDF_CTRL_EXT_MODE];
  wire p34 = ext_en && pin_q[`LPDF_PIN_SLV_34];
  wire p56 = ext_en && pin_q[`LPDF_PIN_SLV_56] && !p34;
  wire p12 = ext_en && pin_q[`LPDF_PIN_MST_12];
  wire slv_txd_w;
  wire mst_txd_w;
  wire slv_rxf_w;
  wire mst_rxf_w;
  wire slv_txen_w;
  wire mst_txen_w;
  wire slv_tmo_w;
  wire mst_tmo_w;
  // slave tx source: controller line or alternate source
  assign slv_txd_w = ctrl_src ? s_alt_tx : I_SLV_CTRL_TX;
  // lin switch leaves master phy idle recessive
  assign mst_txd_w = sw_en ? 1'b1 : I_MST_CTRL_TX;
  // one monitor per transceiver, no shared state
  lpdf_chan #(.TMO_CYC(TX_TMO_CYC)) u_slv (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_rx_raw(s_slv_rx),
    .i_thr_rise(slv_filt_q[15:8]),
    .i_thr_fall(slv_filt_q[7:0]),
    .i_txd(slv_txd_w),
    .o_rx_filt(slv_rxf_w),
    .o_tx_en(slv_txen_w),
    .o_tmo_pulse(slv_tmo_w)
  );
  lpdf_chan #(.TMO_CYC(TX_TMO_CYC)) u_mst (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_rx_raw(s_mst_rx),
    .i_thr_rise(mst_filt_q[15:8]),
    .i_thr_fall(mst_filt_q[7:0]),
    .i_txd(mst_txd_w),
    .o_rx_filt(mst_rxf_w),
    .o_tx_en(mst_txen_w),
    .o_tmo_pulse(mst_tmo_w)
  );
  // ****************************************
  // short to ground pull-up cut
  // ****************************************
  // no power-state gating here, so it also holds in hibernate
  wire pu_off_w = short_en && s_short;
  logic pu_off_q;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) pu_off_q <= 1'b0;
    else pu_off_q <= pu_off_w;
  end
  assign ev_w = {pu_off_w && !pu_off_q, mst_tmo_w, slv_tmo_w};
  assign O_SLV_PULLUP_EN = !pu_off_q;
  // ****************************************
  // routing to phys, controllers and pins
  // ****************************************
  // external mode bypasses internal slave phy
  assign O_SLV_PHY_TX = ext_en ? 1'b1 : slv_txd_w;
  assign O_SLV_PHY_TX_EN = slv_txen_w && !ext_en;
  assign O_MST_PHY_TX = p12 ? 1'b1 : mst_txd_w;
  assign O_MST_PHY_TX_EN = mst_txen_w && !p12 && !sw_en;
  assign O_SLV_CTRL_RX = p34 ? s_gpio[3] : p56 ? s_gpio[5] :
                         ext_en ? 1'b1 : slv_rxf_w;
  assign O_MST_CTRL_RX = p12 ? s_gpio[1] :
                         sw_en ? 1'b1 : mst_rxf_w;
  // rx on odd pin (input), tx on even pin (driven)
  assign O_GPIO = {I_SLV_CTRL_TX, 1'b1, I_SLV_CTRL_TX, 1'b1,
                   I_MST_CTRL_TX, 1'b1};
  assign O_GPIO_OE = {p56, 1'b0, p34, 1'b0, p12, 1'b0};
  // ****************************************
  // read port
  // ****************************************
  wire [31:0] rmux_w =
    hit(I_ADDR, `LPDF_OFF_SLV_FILT) ? {16'h0000, slv_filt_q} :
    hit(I_ADDR, `LPDF_OFF_MST_FILT) ? {16'h0000, mst_filt_q} :
    hit(I_ADDR, `LPDF_OFF_CTRL) ? {28'h0000000, ctrl_q} :
    hit(I_ADDR, `LPDF_OFF_PINSEL) ? {29'h00000000, pin_q} :
    hit(I_ADDR, `LPDF_OFF_STATUS) ? {29'h00000000, stat_q} :
    hit(I_ADDR, `LPDF_OFF_IRQ_EN) ? {29'h00000000, irqen_q} :
    hit(I_ADDR, `LPDF_OFF_LIVE) ?
      {26'h0000000, O_SLV_PULLUP_EN, mst_txen_w, slv_txen_w,
       mst_rxf_w, slv_rxf_w, s_short} :
    32'h00000000;
  // data only in cycle after the read strobe
  always_ff @(posedge I_MCLK) begin
    if (I_RST) rdata_q <= 32'h00000000;
    else rdata_q <= I_RD ? rmux_w : 32'h00000000;
  end
  assign O_RDATA = rdata_q;
endmodule : lpdf_top

//--- dv/lpdf_bus_model.sv
// lin bus seen through both integrated phys
// assumes phy tx low is dominant while its driver is on
`timescale 1ns/1ps
// ****************************************
// bus model
// ****************************************
module lpdf_bus_model (
  input wire logic i_slv_tx,
  input wire logic i_slv_en,
  input wire logic i_mst_tx,
  input wire logic i_mst_en,
  input wire logic i_short,
  input wire logic i_slv_noise,
  input wire logic i_mst_noise,
  output logic o_slv_rx,
  output logic o_mst_rx,
  output logic o_short_flag
);
  // wired-and with pull-up; a spike pulls either line dominant, a short only the slave line
  assign o_slv_rx = ~(i_short | i_slv_noise | (i_slv_en & ~i_slv_tx));
  assign o_mst_rx = ~(i_mst_noise | (i_mst_en & ~i_mst_tx));
  // idle monitor flag stands while the bus is shorted
  assign o_short_flag = i_short;
endmodule : lpdf_bus_model

//--- dv/lpdf_monitor.sv
// port checker for the lin front end top
// assumes bind onto lpdf_top, one clock I_MCLK
`timescale 1ns/1ps
// ****************************************
// checker
// ****************************************
module lpdf_monitor #(
  parameter int TX_TMO_CYC = 16
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_MST_CTRL_TX,
  input wire logic I_SLV_CTRL_TX,
  input wire logic I_SLV_PHY_RX,
  input wire logic I_SLV_SHORT_GND,
  input wire logic O_SLV_CTRL_RX,
  input wire logic O_SLV_PHY_TX,
  input wire logic O_SLV_PHY_TX_EN,
  input wire logic O_MST_PHY_TX_EN,
  input wire logic O_SLV_PULLUP_EN,
  input wire logic [6:1] O_GPIO,
  input wire logic [6:1] O_GPIO_OE
);
  logic [15:0] low_q;
  logic [15:0] low_d;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // run of low master txd samples, saturating
  assign low_d = I_MST_CTRL_TX ? 16'h0000 : low_q + {15'h0000, ~&low_q};
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_d;
    end
  end
  sequence s_stuck;
    low_q > TX_TMO_CYC;
  endsequence
  sequence s_short_seen;
    $past(I_SLV_SHORT_GND, 3);
  endsequence
  // one cycle of slack against the trip edge
  AST_MST_STUCK_OFF: assert property (s_stuck |-> !O_MST_PHY_TX_EN)
    else $error("master driver on after stuck txd");
  AST_SLV_FILT_HOLD: assert property ($changed(O_SLV_CTRL_RX) &&
    $stable(O_GPIO_OE) && O_GPIO_OE == 6'h00 |->
    O_SLV_CTRL_RX == $past(I_SLV_PHY_RX, 3)) else $error("rx flip early");
  AST_PU_CAUSE: assert property ($fell(O_SLV_PULLUP_EN) |->
    s_short_seen) else $error("pull-up cut without short");
  AST_MST_PIN_TX: assert property (O_GPIO_OE[2] |->
    O_GPIO[2] == I_MST_CTRL_TX) else $error("master pin tx wrong");
  AST_SLV_PIN_TX: assert property (O_GPIO_OE[4] |->
    O_GPIO[4] == I_SLV_CTRL_TX) else $error("slave pin tx wrong");
  AST_PIN_EXCL: assert property (!(O_GPIO_OE[4] && O_GPIO_OE[6]))
    else $error("both slave pin pairs driven");
  AST_ODD_IN: assert property ((O_GPIO_OE[5:1] & 5'h15) == 5'h00)
    else $error("receive pin driven");
  AST_SLV_BYPASS: assert property (O_GPIO_OE[4] |->
    O_SLV_PHY_TX && !O_SLV_PHY_TX_EN) else $error("slave phy not bypassed");
endmodule : lpdf_monitor
bind lpdf_top lpdf_monitor #(.TX_TMO_CYC(TX_TMO_CYC)) u_mon (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_MST_CTRL_TX(I_MST_CTRL_TX),
  .I_SLV_CTRL_TX(I_SLV_CTRL_TX), .I_SLV_PHY_RX(I_SLV_PHY_RX),
  .I_SLV_SHORT_GND(I_SLV_SHORT_GND), .O_SLV_CTRL_RX(O_SLV_CTRL_RX),
  .O_SLV_PHY_TX(O_SLV_PHY_TX), .O_SLV_PHY_TX_EN(O_SLV_PHY_TX_EN),
  .O_MST_PHY_TX_EN(O_MST_PHY_TX_EN), .O_SLV_PULLUP_EN(O_SLV_PULLUP_EN),
  .O_GPIO(O_GPIO), .O_GPIO_OE(O_GPIO_OE));

//--- dv/lpdf_top_tb.sv
// self-checking bench for the lin phy digital front end
// assumes the bus model on the phy side and a 125 MHz clock
`timescale 1ns/1ps
`include "lpdf_regs.svh"
// ****************************************
// bench top
// ****************************************
module lpdf_top_tb;
  localparam int TMO = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic s_ctx = 1'b1;
  logic m_ctx = 1'b1;
  logic alt = 1'b1;
  logic shrt = 1'b0;
  logic s_nz = 1'b0;
  logic m_nz = 1'b0;
  logic [6:1] gpi = 6'h3F;
  logic [31:0] rdata;
  logic irq, s_rx, m_rx, s_flag, s_crx, m_crx, s_ptx, s_pen, m_ptx, m_pen, pu;
  logic [6:1] gpo;
  logic [6:1] oe;
  int errors = 0;
  int total_checks = 0;
  // bus clock
  always #4 clk = ~clk;
  lpdf_top #(.TX_TMO_CYC(TMO)) u_dut (
    .I_MCLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_SLV_PHY_RX(s_rx),
    .I_MST_PHY_RX(m_rx), .I_SLV_CTRL_TX(s_ctx), .I_MST_CTRL_TX(m_ctx),
    .I_ALT_TX(alt), .I_SLV_SHORT_GND(s_flag), .O_SLV_CTRL_RX(s_crx),
    .O_MST_CTRL_RX(m_crx), .O_SLV_PHY_TX(s_ptx), .O_SLV_PHY_TX_EN(s_pen),
    .O_MST_PHY_TX(m_ptx), .O_MST_PHY_TX_EN(m_pen), .O_SLV_PULLUP_EN(pu),
    .I_GPIO(gpi), .O_GPIO(gpo), .O_GPIO_OE(oe));
  lpdf_bus_model u_bus (
    .i_slv_tx(s_ptx), .i_slv_en(s_pen), .i_mst_tx(m_ptx), .i_mst_en(m_pen),
    .i_short(shrt), .i_slv_noise(s_nz), .i_mst_noise(m_nz), .o_slv_rx(s_rx),
    .o_mst_rx(m_rx), .o_short_flag(s_flag));
  // shared compare, write, read, wait and spike helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  task automatic nz(input logic v, input int n);
    @(posedge clk);
    s_nz <= v;
    cyc(n);
  endtask : nz
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`LPDF_OFF_SLV_FILT, 32'h0000_3030);
    rd_chk(`LPDF_OFF_MST_FILT, 32'h0000_3030);
    rd_chk(8'h20, 32'h0000_0000);
    // fall threshold 6, rise 4: a five-cycle run flips one way only
    wr_reg(`LPDF_OFF_SLV_FILT, 32'h0000_0406);
    nz(1'b1, 4);
    nz(1'b0, 2);
    chk(32'(s_crx), 32'h1);
    nz(1'b1, 12);
    chk(32'(s_crx), 32'h0);
    nz(1'b0, 4);
    nz(1'b1, 3);
    chk(32'(s_crx), 32'h1);
    nz(1'b0, 12);
    // master lane at its reset threshold of 48
    @(posedge clk) m_nz <= 1'b1;
    cyc(40);
    chk(32'(m_crx), 32'h1);
    cyc(20);
    chk(32'(m_crx), 32'h0);
    @(posedge clk) m_nz <= 1'b0;
    // master txd stuck low trips its own monitor
    @(posedge clk) m_ctx <= 1'b0;
    cyc(TMO + 4);
    rd_chk(`LPDF_OFF_STATUS, 32'h0000_0002);
    wr_reg(`LPDF_OFF_IRQ_EN, 32'h0000_0002);
    chk(32'({irq, m_pen}), 32'h2);
    @(posedge clk) m_ctx <= 1'b1;
    cyc(3);
    chk(32'(m_pen), 32'h1);
    wr_reg(`LPDF_OFF_IRQ_CLR, 32'h0000_0002);
    chk(32'(irq), 32'h0);
    // one high sample restarts the count
    @(posedge clk) m_ctx <= 1'b0;
    cyc(TMO - 4);
    @(posedge clk) m_ctx <= 1'b1;
    @(posedge clk) m_ctx <= 1'b0;
    cyc(TMO - 4);
    chk(32'(m_pen), 32'h1);
    @(posedge clk) m_ctx <= 1'b1;
    // slave trip is masked from the interrupt
    @(posedge clk) s_ctx <= 1'b0;
    cyc(TMO + 4);
    chk(32'({s_pen, irq}), 32'h0);
    @(posedge clk) s_ctx <= 1'b1;
    rd_chk(`LPDF_OFF_STATUS, 32'h0000_0001);
    wr_reg(`LPDF_OFF_IRQ_CLR, 32'h0000_0001);
    // alternate source drives the slave phy
    wr_reg(`LPDF_OFF_CTRL, 32'h0000_0001);
    @(posedge clk) alt <= 1'b0;
    cyc(4);
    chk(32'(s_ptx), 32'h0);
    @(posedge clk) alt <= 1'b1;
    // short cuts the pull-up only with protection on
    @(posedge clk) shrt <= 1'b1;
    cyc(6);
    chk(32'(pu), 32'h1);
    @(posedge clk) shrt <= 1'b0;
    wr_reg(`LPDF_OFF_CTRL, 32'h0000_0002);
    @(posedge clk) shrt <= 1'b1;
    cyc(5);
    chk(32'(pu), 32'h0);
    rd_chk(`LPDF_OFF_STATUS, 32'h0000_0004);
    @(posedge clk) shrt <= 1'b0;
    // lin switch: master phy recessive and off, rx idle
    @(posedge clk) m_ctx <= 1'b0;
    wr_reg(`LPDF_OFF_CTRL, 32'h0000_0004);
    chk(32'({m_ptx, m_pen, m_crx}), 32'h5);
    @(posedge clk) m_ctx <= 1'b1;
    // external transceiver mode, then the other slave pair
    wr_reg(`LPDF_OFF_PINSEL, 32'h0000_0007);
    wr_reg(`LPDF_OFF_CTRL, 32'h0000_0008);
    @(posedge clk) s_ctx <= 1'b0;
    @(posedge clk) gpi <= 6'h3A;
    cyc(4);
    chk(32'({oe, gpo[4], gpo[2], s_crx, m_crx}), 32'hA4);
    chk(32'({s_ptx, s_pen}), 32'h2);
    wr_reg(`LPDF_OFF_PINSEL, 32'h0000_0006);
    chk(32'({oe, gpo[6], s_crx}), 32'h0000_0089);
    @(posedge clk) s_ctx <= 1'b1;
    wr_reg(`LPDF_OFF_CTRL, 32'h0000_0000);
    end_of_test();
  end
  // hang guard, well beyond the few hundred cycles used
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : lpdf_top_tb
